// file: common/mmuc_pkg.sv
// Shared constants and types for the memory-management control unit
package mmuc_pkg;
   localparam int unsigned WORD_W      = 32;
   localparam int unsigned SR_NUM      = 16;
   localparam int unsigned SR_IDX_W    = 4;
   localparam int unsigned BAT_NUM     = 32;
   localparam int unsigned BAT_IDX_W   = 5;
   localparam int unsigned TLB_SETS    = 32;
   localparam int unsigned TLB_IDX_W   = 5;
   localparam int unsigned TLB_WAYS    = 2;
   localparam int unsigned SYNC_STAGES = 3;
   // Bit positions, little-endian numbering (big-endian bit n is 31-n)
   localparam int unsigned EA_IDX_HI   = 16;
   localparam int unsigned EA_IDX_LO   = 12;
   localparam int unsigned SEG_SEL_HI  = 31;
   localparam int unsigned SEG_SEL_LO  = 28;
   localparam int unsigned SR_T_BIT    = 31;
   localparam int unsigned SR_VSID_HI  = 23;
   localparam int unsigned EA_API_HI   = 27;
   localparam int unsigned EA_API_LO   = 22;
   localparam logic [WORD_W-1:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [3:0] {
      MMUC_OP_MTSR,
      MMUC_OP_MTSRIN,
      MMUC_OP_MFSR,
      MMUC_OP_MFSRIN,
      MMUC_OP_TLBIE,
      MMUC_OP_TLBSYNC,
      MMUC_OP_TLBLI,
      MMUC_OP_TLBLD,
      MMUC_OP_TLBIA,
      MMUC_OP_MTBAT,
      MMUC_OP_MFBAT,
      MMUC_OP_MTPPW
   } mmuc_op_t;

   typedef enum logic {
      MMUC_ST_RUN,
      MMUC_ST_HOLD
   } mmuc_state_t;
endpackage : mmuc_pkg

// file: logic/mmuc_sync3.sv
// Three-stage synchroniser with agreement filter for the sync-hold pin
`timescale 1ns/1ns
`default_nettype none
module mmuc_sync3 (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   // Pin and filtered level
   input  wire logic i_async,
   output logic      o_level
);
   logic s1_r, s2_r, s3_r, lvl_r;
   logic lvl_nxt;

   // Level only moves once the two late stages agree
   always_comb begin
      lvl_nxt = (s2_r == s3_r) ? s2_r : lvl_r;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         lvl_r <= 1'b0;
      end else begin
         s1_r  <= i_async;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   assign o_level = lvl_r;
endmodule : mmuc_sync3
`default_nettype wire

// file: logic/mmuc_tlb.sv
// Two-way set-associative translation buffer: invalidate, load, look up
`timescale 1ns/1ns
`default_nettype none
module mmuc_tlb #(
   parameter int unsigned SETS  = 32,
   parameter int unsigned IDX_W = 5
) (
   // Clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_b,
   // Invalidate both ways of one set
   input  wire logic                        i_inv,
   input  wire logic [IDX_W-1:0]            i_inv_idx,
   // Load one entry
   input  wire logic                        i_ld,
   input  wire logic [IDX_W-1:0]            i_ld_idx,
   input  wire logic                        i_ld_way,
   input  wire logic [mmuc_pkg::WORD_W-1:0] i_ld_cmp,
   input  wire logic [mmuc_pkg::WORD_W-1:0] i_ld_ppw,
   // Lookup
   input  wire logic [IDX_W-1:0]            i_lk_idx,
   input  wire logic [mmuc_pkg::WORD_W-1:0] i_lk_cmp,
   output logic                             o_lk_hit,
   output logic [mmuc_pkg::WORD_W-1:0]      o_lk_ppw
);
   import mmuc_pkg::*;
   logic [TLB_WAYS-1:0] vld_r   [SETS];
   logic [TLB_WAYS-1:0] vld_nxt [SETS];
   logic [WORD_W-1:0]   cmp_r   [SETS][TLB_WAYS];
   logic [WORD_W-1:0]   cmp_nxt [SETS][TLB_WAYS];
   logic [WORD_W-1:0]   ppw_r   [SETS][TLB_WAYS];
   logic [WORD_W-1:0]   ppw_nxt [SETS][TLB_WAYS];

   always_comb begin
      vld_nxt = vld_r;
      cmp_nxt = cmp_r;
      ppw_nxt = ppw_r;
      if (i_ld) begin
         vld_nxt[i_ld_idx][i_ld_way] = 1'b1;
         cmp_nxt[i_ld_idx][i_ld_way] = i_ld_cmp;
         ppw_nxt[i_ld_idx][i_ld_way] = i_ld_ppw;
      end
      // Invalidate after load so a clash leaves the set empty
      if (i_inv) begin
         vld_nxt[i_inv_idx] = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int s = 0; s < SETS; s++) begin
            vld_r[s] <= '0;
            for (int w = 0; w < TLB_WAYS; w++) begin
               cmp_r[s][w] <= RESET_WORD;
               ppw_r[s][w] <= RESET_WORD;
            end
         end
      end else begin
         vld_r <= vld_nxt;
         cmp_r <= cmp_nxt;
         ppw_r <= ppw_nxt;
      end
   end

   always_comb begin
      o_lk_hit = 1'b0;
      o_lk_ppw = RESET_WORD;
      for (int w = 0; w < TLB_WAYS; w++) begin
         if (vld_r[i_lk_idx][w] && cmp_r[i_lk_idx][w] == i_lk_cmp) begin
            o_lk_hit = 1'b1;
            o_lk_ppw = ppw_r[i_lk_idx][w];
         end
      end
   end

   logic [IDX_W-1:0] inv_idx_q, ld_idx_q;
   logic             ld_way_q;
   always_ff @(posedge i_clk) begin
      inv_idx_q <= i_inv_idx;
      ld_idx_q  <= i_ld_idx;
      ld_way_q  <= i_ld_way;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   inv_clears_set_a: assert property (i_inv |=> vld_r[inv_idx_q] == '0)
      else $error("invalidate left a way valid");
   load_sets_entry_a: assert property (i_ld && !i_inv |=> vld_r[ld_idx_q][ld_way_q])
      else $error("loaded entry not valid");
endmodule : mmuc_tlb
`default_nettype wire

// file: logic/mmuc_top.sv
// Memory-management control operations: segments, block regs, buffer ops
// Operation
// - Invalidate-all operation is not implemented; it reports illegal instruction.
// - Invalidate-entry clears valid bits of entries chosen by the address in second source.
// - One invalidate clears both ways in instruction and data buffers, four entries.
// - Invalidate set index comes from address bits 15 to 19.
// - With sync-hold negated, execution continues after the sync operation completes.
// - With sync-hold asserted, execution stops after sync until the signal negates.
// - Load-instruction writes instruction compare and physical word into instruction buffer.
// - Load-data writes data compare and physical word into data buffer.
// - Direct move-to-segment writes source register into numbered segment register.
// - Indirect move-to-segment selects segment by second source bits 0 to 3.
// - Direct move-from-segment copies named segment register to destination.
// - Indirect move-from-segment copies segment chosen by second source bits 0 to 3.
// - Sixteen 32-bit segment registers, reached only by the four segment moves.
// - Segment fields are interpreted by the register's most significant bit.
// - Thirty-two 32-bit block registers: eight instruction and eight data pairs.
// - All block registers readable and writable regardless of configuration bit 13.
// - These registers and operations work only at supervisor privilege.
// - On a buffer miss the compare register is derived from the missing access.
`timescale 1ns/1ns
`default_nettype none
module mmuc_top (
   // Clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_b,
   // Operation request from the sequencer
   input  wire logic                        i_op_valid,
   input  wire mmuc_pkg::mmuc_op_t          i_op,
   input  wire logic                        i_supervisor,
   input  wire logic [mmuc_pkg::SR_IDX_W-1:0]  i_sr_num,
   input  wire logic [mmuc_pkg::BAT_IDX_W-1:0] i_bat_idx,
   input  wire logic                        i_ld_way,
   input  wire logic [mmuc_pkg::WORD_W-1:0] i_src,
   input  wire logic [mmuc_pkg::WORD_W-1:0] i_src_b,
   // External sync-hold pin
   input  wire logic                        i_sync_hold,
   // Miss event from the translation path
   input  wire logic                        i_miss_valid,
   input  wire logic                        i_miss_instr,
   input  wire logic [mmuc_pkg::WORD_W-1:0] i_miss_ea,
   // Translation lookup
   input  wire logic                        i_lk_valid,
   input  wire logic                        i_lk_instr,
   input  wire logic [mmuc_pkg::WORD_W-1:0] i_lk_ea,
   // Answers
   output logic                             o_busy,
   output logic                             o_done,
   output logic                             o_rd_valid,
   output logic [mmuc_pkg::WORD_W-1:0]      o_rd_data,
   output logic                             o_illegal,
   output logic                             o_priv_exc,
   output logic                             o_lk_hit,
   output logic [mmuc_pkg::WORD_W-1:0]      o_lk_ppw
);
   import mmuc_pkg::*;

   // Compare word: valid flag from segment type, segment id, hash bit 0, page index
   function automatic logic [WORD_W-1:0] make_cmp(input logic [WORD_W-1:0] sr,
                                                   input logic [WORD_W-1:0] ea);
      make_cmp = {~sr[SR_T_BIT], sr[SR_VSID_HI:0], 1'b0, ea[EA_API_HI:EA_API_LO]};
   endfunction : make_cmp

   function automatic logic [TLB_IDX_W-1:0] set_of(input logic [WORD_W-1:0] ea);
      set_of = ea[EA_IDX_HI:EA_IDX_LO];
   endfunction : set_of

   function automatic logic [SR_IDX_W-1:0] sr_of(input logic [WORD_W-1:0] ea);
      sr_of = ea[SEG_SEL_HI:SEG_SEL_LO];
   endfunction : sr_of

   logic [WORD_W-1:0] sr_r  [SR_NUM];
   logic [WORD_W-1:0] sr_nxt[SR_NUM];
   logic [WORD_W-1:0] bat_r  [BAT_NUM]; // idx 0-15 instr, 16-31 data, bit0 = lower
   logic [WORD_W-1:0] bat_nxt[BAT_NUM];
   logic [WORD_W-1:0] icomp_r, icomp_nxt, dcomp_r, dcomp_nxt, ppw_r, ppw_nxt;
   logic [WORD_W-1:0] imiss_r, imiss_nxt, dmiss_r, dmiss_nxt;
   mmuc_state_t       st_r, st_nxt;
   logic              busy_nxt, done_nxt, rdv_nxt, ill_nxt, priv_nxt;
   logic [WORD_W-1:0] rd_nxt;
   logic              hit_nxt;
   logic [WORD_W-1:0] lkp_nxt;
   logic              hold_lvl;
   logic              go, legal_go;
   logic              inv_go, ildi_go, ldd_go;
   logic              ihit, dhit;
   logic [WORD_W-1:0] ippw, dppw, lk_cmp;

   mmuc_sync3 u_hold_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_async (i_sync_hold),
      .o_level (hold_lvl)
   );

   // Requests are ignored while stalled behind a sync
   assign go       = i_op_valid && !o_busy;
   assign legal_go = go && i_op != MMUC_OP_TLBIA && i_supervisor;
   assign inv_go   = legal_go && i_op == MMUC_OP_TLBIE;
   assign ildi_go  = legal_go && i_op == MMUC_OP_TLBLI;
   assign ldd_go   = legal_go && i_op == MMUC_OP_TLBLD;
   assign lk_cmp   = make_cmp(sr_r[sr_of(i_lk_ea)], i_lk_ea);

   // Instruction buffer
   mmuc_tlb #(.SETS(TLB_SETS), .IDX_W(TLB_IDX_W)) u_ibuf (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_inv     (inv_go),
      .i_inv_idx (set_of(i_src_b)),
      .i_ld      (ildi_go),
      .i_ld_idx  (set_of(imiss_r)),
      .i_ld_way  (i_ld_way),
      .i_ld_cmp  (icomp_r),
      .i_ld_ppw  (ppw_r),
      .i_lk_idx  (set_of(i_lk_ea)),
      .i_lk_cmp  (lk_cmp),
      .o_lk_hit  (ihit),
      .o_lk_ppw  (ippw)
   );

   // Data buffer
   mmuc_tlb #(.SETS(TLB_SETS), .IDX_W(TLB_IDX_W)) u_dbuf (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_inv     (inv_go),
      .i_inv_idx (set_of(i_src_b)),
      .i_ld      (ldd_go),
      .i_ld_idx  (set_of(dmiss_r)),
      .i_ld_way  (i_ld_way),
      .i_ld_cmp  (dcomp_r),
      .i_ld_ppw  (ppw_r),
      .i_lk_idx  (set_of(i_lk_ea)),
      .i_lk_cmp  (lk_cmp),
      .o_lk_hit  (dhit),
      .o_lk_ppw  (dppw)
   );

   always_comb begin
      sr_nxt    = sr_r;
      bat_nxt   = bat_r;
      icomp_nxt = icomp_r;
      dcomp_nxt = dcomp_r;
      ppw_nxt   = ppw_r;
      imiss_nxt = imiss_r;
      dmiss_nxt = dmiss_r;
      st_nxt    = st_r;
      done_nxt  = 1'b0;
      rdv_nxt   = 1'b0;
      rd_nxt    = o_rd_data;
      ill_nxt   = 1'b0;
      priv_nxt  = 1'b0;
      // Direct-store segments give a clear valid flag, so they never hit
      hit_nxt   = i_lk_valid && lk_cmp[WORD_W-1] && (i_lk_instr ? ihit : dhit);
      lkp_nxt   = i_lk_instr ? ippw : dppw;
      if (i_miss_valid) begin
         if (i_miss_instr) begin
            imiss_nxt = i_miss_ea;
            icomp_nxt = make_cmp(sr_r[sr_of(i_miss_ea)], i_miss_ea);
         end else begin
            dmiss_nxt = i_miss_ea;
            dcomp_nxt = make_cmp(sr_r[sr_of(i_miss_ea)], i_miss_ea);
         end
      end
      unique case (st_r)
         MMUC_ST_RUN: begin
            if (go && i_op == MMUC_OP_TLBIA) begin
               ill_nxt = 1'b1;
            end else if (go && !i_supervisor) begin
               priv_nxt = 1'b1;
            end else if (go) begin
               done_nxt = 1'b1;
               unique case (i_op)
                  MMUC_OP_MTSR:   sr_nxt[i_sr_num] = i_src;
                  MMUC_OP_MTSRIN: sr_nxt[sr_of(i_src_b)] = i_src;
                  MMUC_OP_MFSR: begin
                     rdv_nxt = 1'b1;
                     rd_nxt  = sr_r[i_sr_num];
                  end
                  MMUC_OP_MFSRIN: begin
                     rdv_nxt = 1'b1;
                     rd_nxt  = sr_r[sr_of(i_src_b)];
                  end
                  MMUC_OP_MTBAT:  bat_nxt[i_bat_idx] = i_src;
                  MMUC_OP_MFBAT: begin
                     rdv_nxt = 1'b1;
                     rd_nxt  = bat_r[i_bat_idx];
                  end
                  MMUC_OP_MTPPW:  ppw_nxt = i_src;
                  MMUC_OP_TLBSYNC: begin
                     if (hold_lvl) begin
                        st_nxt   = MMUC_ST_HOLD;
                        done_nxt = 1'b0;
                     end
                  end
                  default: ; // Buffer invalidate and loads act in the buffers
               endcase
            end
         end
         MMUC_ST_HOLD: begin
            if (!hold_lvl) begin
               st_nxt   = MMUC_ST_RUN;
               done_nxt = 1'b1;
            end
         end
      endcase
      busy_nxt = (st_nxt == MMUC_ST_HOLD);
   end

   // Block registers reset to zero so no stale valid bit can match
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < SR_NUM; i++) sr_r[i] <= RESET_WORD;
         for (int i = 0; i < BAT_NUM; i++) bat_r[i] <= RESET_WORD;
         icomp_r    <= RESET_WORD;
         dcomp_r    <= RESET_WORD;
         ppw_r      <= RESET_WORD;
         imiss_r    <= RESET_WORD;
         dmiss_r    <= RESET_WORD;
         st_r       <= MMUC_ST_RUN;
         o_busy     <= 1'b0;
         o_done     <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data  <= RESET_WORD;
         o_illegal  <= 1'b0;
         o_priv_exc <= 1'b0;
         o_lk_hit   <= 1'b0;
         o_lk_ppw   <= RESET_WORD;
      end else begin
         sr_r       <= sr_nxt;
         bat_r      <= bat_nxt;
         icomp_r    <= icomp_nxt;
         dcomp_r    <= dcomp_nxt;
         ppw_r      <= ppw_nxt;
         imiss_r    <= imiss_nxt;
         dmiss_r    <= dmiss_nxt;
         st_r       <= st_nxt;
         o_busy     <= busy_nxt;
         o_done     <= done_nxt;
         o_rd_valid <= rdv_nxt;
         o_rd_data  <= rd_nxt;
         o_illegal  <= ill_nxt;
         o_priv_exc <= priv_nxt;
         o_lk_hit   <= hit_nxt;
         o_lk_ppw   <= lkp_nxt;
      end
   end

   // Helper state for the checks below
   logic [SR_IDX_W-1:0]  num_q;
   logic [WORD_W-1:0]    sr_in_q, sr_sel_q;
   always_ff @(posedge i_clk) begin
      num_q    <= i_sr_num;
      sr_in_q  <= sr_r[sr_of(i_src_b)];
      sr_sel_q <= sr_r[i_sr_num];
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence sr_write_s;
      go && i_supervisor && i_op == MMUC_OP_MTSR;
   endsequence
   sequence sr_read_same_s;
      go && i_supervisor && i_op == MMUC_OP_MFSR && i_sr_num == $past(i_sr_num, 2);
   endsequence
   sequence bat_write_s;
      go && i_supervisor && i_op == MMUC_OP_MTBAT;
   endsequence
   sequence bat_read_same_s;
      go && i_supervisor && i_op == MMUC_OP_MFBAT && i_bat_idx == $past(i_bat_idx, 2);
   endsequence

   invalidate_all_a: assert property (go && i_op == MMUC_OP_TLBIA
      |=> o_illegal && !o_done && !o_priv_exc)
      else $error("invalidate-all not reported illegal");
   user_blocked_a: assert property (go && !i_supervisor && i_op == MMUC_OP_MTSR
      |=> o_priv_exc && !o_done && sr_r[num_q] == sr_sel_q)
      else $error("user move changed state or was not trapped");
   invalidate_index_a: assert property (inv_go |-> u_ibuf.i_inv_idx == i_src_b[16:12])
      else $error("invalidate index taken from wrong address bits");
   sync_stop_a: assert property (go && i_op == MMUC_OP_TLBSYNC && i_supervisor && hold_lvl
      |=> o_busy && !o_done)
      else $error("sync did not stop execution under hold");
   sync_stays_a: assert property (o_busy && hold_lvl |=> o_busy)
      else $error("stall released while hold still asserted");
   sync_resume_a: assert property (go && i_op == MMUC_OP_TLBSYNC && i_supervisor && !hold_lvl
      |=> o_done && !o_busy)
      else $error("sync did not complete with hold negated");
   // An idle cycle between write and read keeps a second write out of the window
   sr_readback_a: assert property (sr_write_s ##1 !go ##1 sr_read_same_s
      |=> o_rd_valid && o_rd_data == $past(i_src, 3))
      else $error("segment readback mismatch");
   sr_indirect_a: assert property (go && i_supervisor && i_op == MMUC_OP_MFSRIN
      |=> o_rd_valid && o_rd_data == sr_in_q)
      else $error("indirect segment read wrong");
   bat_readback_a: assert property (bat_write_s ##1 !go ##1 bat_read_same_s
      |=> o_rd_valid && o_rd_data == $past(i_src, 3))
      else $error("block register readback mismatch");
endmodule : mmuc_top
`default_nettype wire

// file: test/mmuc_hold_model.sv
// Far-side model of the system sync-hold pin
`timescale 1ns/1ns
`default_nettype none
module mmuc_hold_model (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   // Hold request and its length in cycles
   input  wire logic       i_start,
   input  wire logic [7:0] i_len,
   // Pin
   output logic            o_sync_hold
);
   logic [7:0] cnt_r;
   // Pin moves only just after an edge, so the filter sees a clean level
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         cnt_r <= 8'h00;
      else if (i_start)
         cnt_r <= i_len;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end
   assign o_sync_hold = (cnt_r != 8'h00);
endmodule : mmuc_hold_model
`default_nettype wire

// file: test/mmuc_top_test.sv
// Self-checking testbench of the memory-management control unit
`timescale 1ns/1ns
`default_nettype none
module mmuc_top_test;
   import mmuc_pkg::*;
   localparam logic [31:0] EA  = 32'h5000_4000;
   localparam logic [31:0] EA2 = 32'h6000_2000;
   localparam logic [31:0] PPI = 32'h0001_2340;
   localparam logic [31:0] PPD = 32'h0005_6780;
   logic        i_clk, i_rst_b, i_op_valid, i_supervisor, i_ld_way, i_sync_hold;
   mmuc_op_t    i_op;
   logic [3:0]  i_sr_num;
   logic [4:0]  i_bat_idx;
   logic [31:0] i_src, i_src_b, i_miss_ea, i_lk_ea, o_rd_data, o_lk_ppw, flags;
   logic        i_miss_valid, i_miss_instr, i_lk_valid, i_lk_instr;
   logic        o_busy, o_done, o_rd_valid, o_illegal, o_priv_exc, o_lk_hit;
   logic        hold_start;
   int          failures, check_count, cycles;
   // Flag word: busy 10, done 08, read 04, illegal 02, privilege 01
   assign flags = {27'h0, o_busy, o_done, o_rd_valid, o_illegal, o_priv_exc};

   mmuc_top u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_op(i_op),
      .i_supervisor(i_supervisor), .i_sr_num(i_sr_num), .i_bat_idx(i_bat_idx),
      .i_ld_way(i_ld_way), .i_src(i_src), .i_src_b(i_src_b), .i_sync_hold(i_sync_hold),
      .i_miss_valid(i_miss_valid), .i_miss_instr(i_miss_instr), .i_miss_ea(i_miss_ea),
      .i_lk_valid(i_lk_valid), .i_lk_instr(i_lk_instr), .i_lk_ea(i_lk_ea),
      .o_busy(o_busy), .o_done(o_done), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
      .o_illegal(o_illegal), .o_priv_exc(o_priv_exc), .o_lk_hit(o_lk_hit),
      .o_lk_ppw(o_lk_ppw));
   mmuc_hold_model u_hold (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(hold_start),
      .i_len(8'h14), .o_sync_hold(i_sync_hold));

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   task automatic report_and_stop;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Index doubles as segment number, block index and load way
   task automatic op(input mmuc_op_t o, input logic sup, input logic [4:0] ix,
                     input logic [31:0] s, input logic [31:0] sb);
      @(posedge i_clk);
      i_op_valid   <= 1'b1;
      i_op         <= o;
      i_supervisor <= sup;
      i_sr_num     <= ix[3:0];
      i_bat_idx    <= ix;
      i_ld_way     <= ix[0];
      i_src        <= s;
      i_src_b      <= sb;
      @(posedge i_clk);
      i_op_valid <= 1'b0;
      #1;
   endtask : op

   // Lookup when lk is high, otherwise a miss event
   task automatic probe(input logic lk, input logic ins, input logic [31:0] ea);
      @(posedge i_clk);
      i_lk_valid   <= lk;
      i_miss_valid <= !lk;
      i_lk_instr   <= ins;
      i_miss_instr <= ins;
      i_lk_ea      <= ea;
      i_miss_ea    <= ea;
      @(posedge i_clk);
      i_lk_valid   <= 1'b0;
      i_miss_valid <= 1'b0;
      #1;
   endtask : probe

   // Both buffers looked up at EA: instruction first, then data
   task automatic look(input logic hit);
      for (int i = 0; i < 2; i++) begin
         probe(1'b1, (i == 0), EA);
         check({31'h0, o_lk_hit}, {31'h0, hit});
         if (hit)
            check(o_lk_ppw, (i == 0) ? PPI : PPD);
      end
   endtask : look

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         report_and_stop();
      end
   end

   initial begin
      {i_rst_b, i_op_valid, i_supervisor, i_ld_way, hold_start} = '0;
      {i_miss_valid, i_miss_instr, i_lk_valid, i_lk_instr} = '0;
      {i_sr_num, i_bat_idx, i_src, i_src_b, i_miss_ea, i_lk_ea} = '0;
      i_op = MMUC_OP_MTSR;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         op(MMUC_OP_MTSR, 1'b1, 5'(k), 32'h5A00_0000 + k, 32'h0);
         check(flags, 32'h08);
      end
      for (int k = 0; k < 16; k++) begin
         op(MMUC_OP_MFSRIN, 1'b1, 5'h0, 32'h0, {4'(k), 28'hFFF_FFFF});
         check(flags, 32'h0C);
         check(o_rd_data, 32'h5A00_0000 + k);
      end
      op(MMUC_OP_MTSRIN, 1'b1, 5'h0, 32'h1234_5678, 32'hC000_0000);
      op(MMUC_OP_MFSR, 1'b1, 5'h0C, 32'h0, 32'h0);
      check(o_rd_data, 32'h1234_5678);
      for (int k = 0; k < 32; k++)
         op(MMUC_OP_MTBAT, 1'b1, 5'(k), 32'hB000_0000 + 3 * k, 32'h0);
      for (int k = 0; k < 32; k++) begin
         op(MMUC_OP_MFBAT, 1'b1, 5'(k), 32'h0, 32'h0);
         check(o_rd_data, 32'hB000_0000 + 3 * k);
      end
      op(MMUC_OP_MTBAT, 1'b1, 5'h11, 32'h0BAD_0011, 32'h0);
      op(MMUC_OP_MFBAT, 1'b1, 5'h11, 32'h0, 32'h0);
      check(o_rd_data, 32'h0BAD_0011);
      op(MMUC_OP_MTSR, 1'b0, 5'h3, 32'hDEAD_BEEF, 32'h0);
      check(flags, 32'h01);
      op(MMUC_OP_MFSR, 1'b0, 5'h3, 32'h0, 32'h0);
      check(flags, 32'h01);
      op(MMUC_OP_MFSR, 1'b1, 5'h3, 32'h0, 32'h0);
      check(o_rd_data, 32'h5A00_0003);
      for (int s = 0; s < 2; s++) begin
         op(MMUC_OP_TLBIA, 1'(s), 5'h0, 32'h0, 32'h0);
         check(flags, 32'h02);
      end
      op(MMUC_OP_TLBSYNC, 1'b1, 5'h0, 32'h0, 32'h0);
      check(flags, 32'h08);
      // Pin must get through the filter before the sync is issued
      @(posedge i_clk);
      hold_start <= 1'b1;
      @(posedge i_clk);
      hold_start <= 1'b0;
      repeat (6) @(posedge i_clk);
      op(MMUC_OP_TLBSYNC, 1'b1, 5'h0, 32'h0, 32'h0);
      check(flags, 32'h10);
      op(MMUC_OP_MTSR, 1'b1, 5'h2, 32'h0000_0077, 32'h0);
      check(flags, 32'h10);
      for (int n = 0; n < 60 && o_busy !== 1'b0; n++) begin
         @(posedge i_clk);
         #1;
      end
      check(flags, 32'h08);
      op(MMUC_OP_MFSR, 1'b1, 5'h2, 32'h0, 32'h0);
      check(o_rd_data, 32'h5A00_0002);
      op(MMUC_OP_MTSR, 1'b1, 5'h5, 32'h0000_0ABC, 32'h0);
      op(MMUC_OP_MFSR, 1'b1, 5'h5, 32'h0, 32'h0);
      check(o_rd_data, 32'h0000_0ABC);
      probe(1'b0, 1'b1, EA);
      op(MMUC_OP_MTPPW, 1'b1, 5'h0, PPI, 32'h0);
      op(MMUC_OP_TLBLI, 1'b1, 5'h0, 32'h0, 32'h0);
      probe(1'b0, 1'b0, EA);
      op(MMUC_OP_MTPPW, 1'b1, 5'h0, PPD, 32'h0);
      op(MMUC_OP_TLBLD, 1'b1, 5'h1, 32'h0, 32'h0);
      look(1'b1);
      op(MMUC_OP_TLBIE, 1'b1, 5'h0, 32'h0, EA ^ 32'h0000_1000);
      look(1'b1);
      op(MMUC_OP_TLBIE, 1'b1, 5'h0, 32'h0, EA);
      check(flags, 32'h08);
      look(1'b0);
      // A segment with the top bit set must never give a hit
      op(MMUC_OP_MTSR, 1'b1, 5'h6, 32'h8000_0000, 32'h0);
      probe(1'b0, 1'b1, EA2);
      op(MMUC_OP_MTPPW, 1'b1, 5'h0, PPI, 32'h0);
      op(MMUC_OP_TLBLI, 1'b1, 5'h0, 32'h0, 32'h0);
      probe(1'b1, 1'b1, EA2);
      check({31'h0, o_lk_hit}, 32'h0);
      report_and_stop();
   end
endmodule : mmuc_top_test
`default_nettype wire
